// file: proc_ctrl_pkg.sv
/*
 * Package for the processor control register group: register indices, field
 * positions, reset values and timing counts.
 * Assumes a 32-bit AHB-Lite slave with each 16-bit register in the low
 * half of one aligned word; the byte address is four times the index.
 */
package proc_ctrl_pkg;
	// Register indices; the bus byte address is four times the index
	localparam logic [15:0] OFF_BANK = 16'hc002;
	localparam logic [15:0] OFF_REV = 16'hc004;
	localparam logic [15:0] OFF_SPEED = 16'hc008;
	localparam logic [15:0] OFF_POWER = 16'hc00a;
	// Bank register: base field and reset
	localparam int BANK_BASE_LSB = 4;
	localparam logic [15:0] BANK_RESET = 16'h0100;
	localparam logic [15:0] BANK_WMASK = 16'hfff0;
	// CPU divider
	localparam int DIV_W = 4;
	localparam logic [15:0] SPEED_RESET = 16'h000f;
	localparam logic [15:0] SPEED_WMASK = 16'h000f;
	// Power control fields
	localparam int PWR_USB2B = 15;
	localparam int PWR_USB2A = 14;
	localparam int PWR_USB1B = 13;
	localparam int PWR_USB1A = 12;
	localparam int PWR_OTG = 11;
	localparam int PWR_SERIAL = 9;
	localparam int PWR_SELECT = 8;
	localparam int PWR_HOSTRD = 7;
	localparam int PWR_PIN = 4;
	localparam int PWR_BOOST = 2;
	localparam int PWR_SLEEP = 1;
	localparam int PWR_HALT = 0;
	localparam logic [15:0] POWER_RESET = 16'h0000;
	localparam logic [15:0] POWER_WMASK = 16'hfb93;
	// Wake latency: resume within 0.5 ms of an enabled wake event
	localparam int CLK_MHZ = 100;
	localparam int WAKE_TIME_US_X10 = 5000;
	localparam int WAKE_CYCLES = WAKE_TIME_US_X10 * CLK_MHZ / 10;
	// AHB encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// file: proc_ctrl_regs.sv
/*
 * Processor control registers: register bank base, silicon revision,
 * CPU clock divider and power/wake control, as an AHB-Lite slave.
 * Assumes wake and status inputs come from pins or other clock domains
 * and are synchronised here; host read strobe and interrupt request are on this clock.
 */
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
module proc_ctrl_regs
	import proc_ctrl_pkg::*;
#(
	parameter logic [15:0] REVISION = 16'h0a5c, // Arbitrary value
	parameter int WAKE_DELAY = WAKE_CYCLES
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// General register address path
	input wire logic [3:0] i_gen_reg_num,
	output logic [15:0] o_gen_reg_addr,
	// Processor and power control
	output logic o_cpu_clk_en,
	output logic o_cpu_run,
	output logic o_sleep,
	output logic o_halt,
	output logic o_serial_drop_byte,
	// Wake sources and status
	input wire logic [3:0] i_usb_port_line,
	input wire logic i_otg_vbus_valid,
	input wire logic i_otg_id,
	input wire logic i_fast_serial_port_rx,
	input wire logic i_serial_select_low_n,
	input wire logic i_parallel_host_port_rd,
	input wire logic [1:0] i_pin_input_wake,
	input wire logic i_booster_rail_low,
	input wire logic i_irq_pending
);
	localparam int NSYNC = 11;
	typedef enum {PW_RUN, PW_HALT, PW_SLEEP, PW_WAKE} pw_t;

	logic [15:0] bank_q, bank_d, speed_q, speed_d, power_q, power_d;
	logic [NSYNC-1:0] s1_q, s2_q, s3_q, stable_q, stable_d;
	logic [NSYNC-1:0] async_in;
	logic ap_q, ap_d, aw_q, aw_d;
	logic [15:0] aoff_q, aoff_d;
	logic [31:0] rdata_q, rdata_d;
	logic [DIV_W-1:0] div_q, div_d;
	pw_t st_q, st_d;
	logic [31:0] wcnt_q, wcnt_d;
	logic drop_q, drop_d;
	logic wake_ev, wr_pwr;

	function automatic logic [15:0] read_reg(input logic [15:0] off, input logic [15:0] bk,
		input logic [15:0] sp, input logic [15:0] pw, input logic boost);
		logic [15:0] r;
		r = 16'h0000;
		case (off)
			OFF_BANK: r = bk;
			OFF_REV: r = REVISION;
			OFF_SPEED: r = sp;
			OFF_POWER: begin
				r = pw;
				r[PWR_BOOST] = boost;
			end
			default: r = 16'h0000;
		endcase
		return r;
	endfunction

	// Three-stage synchronisers; a change counts once stages two and three agree
	assign async_in = {i_booster_rail_low, i_pin_input_wake, i_serial_select_low_n,
		i_fast_serial_port_rx, i_otg_id, i_otg_vbus_valid, i_usb_port_line[0],
		i_usb_port_line[1], i_usb_port_line[2], i_usb_port_line[3]};
	always_comb begin
		stable_d = stable_q;
		for (int k = 0; k < NSYNC; k++) begin
			if (s2_q[k] == s3_q[k]) begin
				stable_d[k] = s3_q[k];
			end
		end
	end

	// Wake event decode; bit order matches async_in
	always_comb begin
		logic [NSYNC-1:0] tr;
		tr = stable_d ^ stable_q;
		wake_ev = 1'b0;
		if (power_q[PWR_USB1A] && tr[3]) wake_ev = 1'b1;
		if (power_q[PWR_USB1B] && tr[2]) wake_ev = 1'b1;
		if (power_q[PWR_USB2A] && tr[1]) wake_ev = 1'b1;
		if (power_q[PWR_USB2B] && tr[0]) wake_ev = 1'b1;
		if (power_q[PWR_OTG] && (tr[4] || tr[5])) wake_ev = 1'b1;
		if (power_q[PWR_SERIAL] && tr[6]) wake_ev = 1'b1;
		if (power_q[PWR_SELECT] && tr[7] && !stable_d[7]) wake_ev = 1'b1;
		if (power_q[PWR_HOSTRD] && i_parallel_host_port_rd) wake_ev = 1'b1;
		if (power_q[PWR_PIN] && (tr[8] || tr[9])) wake_ev = 1'b1;
	end

	// Bus slave: zero wait states, always OKAY
	always_comb begin
		ap_d = i_hready && i_hsel && (i_htrans == HTRANS_NONSEQ);
		aw_d = ap_d && i_hwrite;
		aoff_d = ap_d ? i_haddr[17:2] : aoff_q;
		bank_d = bank_q;
		speed_d = speed_q;
		power_d = power_q;
		wr_pwr = 1'b0;
		if (aw_q) begin
			case (aoff_q)
				OFF_BANK: begin
					bank_d = i_hwdata[15:0] & BANK_WMASK;
				end
				OFF_SPEED: speed_d = i_hwdata[15:0] & SPEED_WMASK;
				OFF_POWER: begin
					power_d = i_hwdata[15:0] & POWER_WMASK;
					wr_pwr = 1'b1;
				end
				default: ;
			endcase
		end
		// Sleep/halt bits self-clear when the mode ends; the halt bit only if no power register write lands in that cycle
		if (st_q == PW_WAKE && st_d == PW_RUN) begin
			power_d[PWR_SLEEP] = 1'b0;
		end
		if (st_q == PW_HALT && i_irq_pending && !wr_pwr) begin
			power_d[PWR_HALT] = 1'b0;
		end
		rdata_d = 32'h0000_0000;
		if (ap_d && !i_hwrite) begin
			rdata_d = {16'h0000, read_reg(i_haddr[17:2], bank_q, speed_q, power_q,
				stable_q[10])};
		end
	end

	// Divided processor clock enable; peripherals see the full rate
	always_comb begin
		if (div_q >= speed_q[DIV_W-1:0]) div_d = '0;
		else div_d = div_q + 1'b1;
	end

	// Power state machine
	always_comb begin
		st_d = st_q;
		wcnt_d = wcnt_q;
		drop_d = 1'b0;
		case (st_q)
			PW_RUN: begin
				if (wr_pwr && i_hwdata[PWR_SLEEP]) st_d = PW_SLEEP;
				else if (wr_pwr && i_hwdata[PWR_HALT]) st_d = PW_HALT;
			end
			PW_HALT: if (i_irq_pending) st_d = PW_RUN;
			PW_SLEEP: begin
				if (wake_ev) begin
					st_d = PW_WAKE;
					wcnt_d = 32'(WAKE_DELAY - 1);
					drop_d = 1'b1;
				end
			end
			PW_WAKE: begin
				if (wcnt_q == 32'h0000_0000) st_d = PW_RUN;
				else wcnt_d = wcnt_q - 32'h0000_0001;
			end
			default: st_d = PW_RUN;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		s1_q <= async_in;
		s2_q <= s1_q;
		s3_q <= s2_q;
		if (i_rst) begin
			stable_q <= '0;
			ap_q <= 1'b0;
			aw_q <= 1'b0;
			aoff_q <= 16'h0000;
			rdata_q <= 32'h0000_0000;
			bank_q <= BANK_RESET;
			speed_q <= SPEED_RESET;
			power_q <= POWER_RESET;
			div_q <= '0;
			st_q <= PW_RUN;
			wcnt_q <= 32'h0000_0000;
			drop_q <= 1'b0;
		end else begin
			stable_q <= stable_d;
			ap_q <= ap_d;
			aw_q <= aw_d;
			aoff_q <= aoff_d;
			rdata_q <= rdata_d;
			bank_q <= bank_d;
			speed_q <= speed_d;
			power_q <= power_d;
			div_q <= div_d;
			st_q <= st_d;
			wcnt_q <= wcnt_d;
			drop_q <= drop_d;
		end
	end

	assign o_hrdata = rdata_q;
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_gen_reg_addr = {bank_q[15:BANK_BASE_LSB], 4'h0}
		| {11'h000, i_gen_reg_num, 1'b0};
	assign o_cpu_clk_en = (div_q == '0) && (st_q == PW_RUN);
	assign o_cpu_run = (st_q == PW_RUN);
	assign o_sleep = (st_q == PW_SLEEP);
	assign o_halt = (st_q == PW_HALT);
	assign o_serial_drop_byte = drop_q;

	AST_DIV_PERIOD: assert property (@(posedge i_mclk) disable iff (i_rst)
		(div_q == '0) && $stable(speed_q) |=> $changed(speed_q)
		|| ((div_q == '0) == (speed_q[3:0] == 4'h0)))
		else $error("divider period wrong");
	AST_SPEED_WR: assert property (@(posedge i_mclk) disable iff (i_rst)
		aw_q && aoff_q == OFF_SPEED |=> speed_q[3:0] == $past(i_hwdata[3:0]))
		else $error("divider write lost");
	AST_SPEED_RESV: assert property (@(posedge i_mclk) disable iff (i_rst)
		(speed_q & ~SPEED_WMASK) == 16'h0000) else $error("speed reserved set");
	AST_PWR_RESV: assert property (@(posedge i_mclk) disable iff (i_rst)
		(power_q & ~POWER_WMASK) == 16'h0000) else $error("power reserved set");
	AST_SLEEP_BIT: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_sleep |-> power_q[PWR_SLEEP]) else $error("sleep bit clear asleep");
	AST_DROP_ONE: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_serial_drop_byte |=> !o_serial_drop_byte) else $error("drop too long");
	AST_HALT_NO_CLK: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_halt |-> !o_cpu_clk_en && !o_cpu_run) else $error("cpu ran halted");
	AST_WAKE_NO_CLK: assert property (@(posedge i_mclk) disable iff (i_rst)
		st_q == PW_WAKE |-> !o_cpu_clk_en) else $error("cpu ran waking");
	AST_RESP_OKAY: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_hreadyout && !o_hresp) else $error("bus response wrong");
	AST_BANK_LOW: assert property (@(posedge i_mclk) disable iff (i_rst)
		bank_q[3:0] == 4'h0) else $error("bank low bits set");
	AST_ADDR_LSB: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_gen_reg_addr[0] == 1'b0) else $error("address bit zero set");
	AST_SLEEP_ENTER: assert property (@(posedge i_mclk) disable iff (i_rst)
		st_q == PW_RUN && wr_pwr && i_hwdata[1] |=> o_sleep) else $error("no sleep");
	AST_NO_RUN_SLEEP: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_sleep |-> !o_cpu_clk_en) else $error("cpu ran asleep");
	AST_HALT_EXIT: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_halt && i_irq_pending |=> o_cpu_run) else $error("halt stuck");
	AST_WAKE_DROP: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_sleep && wake_ev |=> o_serial_drop_byte ##1 !o_sleep) else $error("wake miss");
	AST_RESET_PWR: assert property (@(posedge i_mclk)
		$past(i_rst) |-> power_q == 16'h0000 && bank_q == 16'h0100) else $error("reset");
	AST_REV_RO: assert property (@(posedge i_mclk) disable iff (i_rst)
		ap_q && !aw_q && aoff_q == OFF_REV |-> o_hrdata[15:0] == REVISION)
		else $error("revision changed");
	COV_SLEEP_WAKE: cover property (@(posedge i_mclk) o_sleep ##1 st_q == PW_WAKE);
	COV_HALT: cover property (@(posedge i_mclk) o_halt ##1 o_cpu_run);
	COV_DIV16: cover property (@(posedge i_mclk) speed_q == 16'h000f && o_cpu_clk_en);
	COV_BANK_WR: cover property (@(posedge i_mclk) aw_q && aoff_q == OFF_BANK);
	COV_HOST_WAKE: cover property (@(posedge i_mclk) o_sleep && i_parallel_host_port_rd);
endmodule

// file: processor_control_regs_bench.sv
/*
 Self-checking bench for proc_ctrl_regs.
 Assumes one 100 MHz clock and a single AHB-Lite master (this bench).
*/
`timescale 1ns/1ps
module processor_control_regs_bench
	import proc_ctrl_pkg::*;
;
	localparam logic [15:0] REV = 16'h3c96; // Arbitrary value
	logic i_mclk = 0, i_rst = 1, hsel = 0, hwrite = 0, vbus = 0, oid = 0, rx = 0;
	logic ssn = 1, hrd = 0, boost = 0, irq = 0;
	logic [1:0] htrans = 0, pins = 0;
	logic [3:0] usb = 0, num = 4'he;
	logic [31:0] haddr = 0, hwdata = 0, rd;
	wire logic [31:0] hrdata;
	wire logic hready, hresp, clk_en, run, slp, hlt, drop;
	wire logic [15:0] gaddr;
	int n_mismatch = 0, cmp_count = 0, cyc = 0, k, p, d;
	logic [15:0] en_tab [11] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800,
		16'h0800, 16'h0200, 16'h0100, 16'h0080, 16'h0010, 16'h0010};

	proc_ctrl_regs #(.REVISION(REV), .WAKE_DELAY(8)) i_dut (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
		.i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
		.i_gen_reg_num(num), .o_gen_reg_addr(gaddr), .o_cpu_clk_en(clk_en),
		.o_cpu_run(run), .o_sleep(slp), .o_halt(hlt), .o_serial_drop_byte(drop),
		.i_usb_port_line(usb), .i_otg_vbus_valid(vbus), .i_otg_id(oid),
		.i_fast_serial_port_rx(rx), .i_serial_select_low_n(ssn),
		.i_parallel_host_port_rd(hrd), .i_pin_input_wake(pins),
		.i_booster_rail_low(boost), .i_irq_pending(irq));

	initial begin
		forever #5 i_mclk = ~i_mclk;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic results;
		$display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			results();
		end
	end

	task automatic cy(input int n);
		repeat (n) @(posedge i_mclk);
	endtask

	// One single AHB transfer; read data taken at the data-phase edge
	task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] dat);
		hsel <= 1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {14'h0000, a, 2'b00};
		hwrite <= w;
		do @(posedge i_mclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= dat;
		do @(posedge i_mclk); while (hready !== 1'b1);
		rd = hrdata;
		chk(hresp, 0);
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] dat);
		bus(1, a, dat);
	endtask

	task automatic rdx(input logic [15:0] a, input logic [31:0] e);
		bus(0, a, 0);
		chk(rd, e);
	endtask

	// Make wake source s change in the direction that should wake
	task automatic poke(input int s);
		case (s)
			0, 1, 2, 3: usb[3-s] <= ~usb[3-s];
			4: vbus <= ~vbus;
			5: oid <= ~oid;
			6: rx <= ~rx;
			7: ssn <= 1'b0;
			8: hrd <= 1'b1;
			default: pins[s-9] <= ~pins[s-9];
		endcase
		@(posedge i_mclk);
		hrd <= 1'b0;
	endtask

	task automatic wake_wait;
		d = 0;
		k = 0;
		while (run !== 1'b1 && k < 200) begin
			@(posedge i_mclk);
			k++;
			if (drop === 1'b1)
				d++;
		end
		chk(run, 1);
		chk(slp, 0);
		chk(d, 1);
	endtask

	initial begin
		cy(20);
		i_rst <= 0;
		cy(1);
		rdx(OFF_BANK, 32'h0000_0100);
		chk(gaddr, 16'h011c);
		rdx(OFF_REV, {16'h0000, REV});
		rdx(OFF_SPEED, {16'h0000, SPEED_RESET});
		rdx(OFF_POWER, 32'h0000_0000);
		wr(OFF_REV, 32'h0000_ffff);
		rdx(OFF_REV, {16'h0000, REV});
		wr(OFF_BANK, 32'h0000_abcd);
		rdx(OFF_BANK, 32'h0000_abc0);
		chk(gaddr, 16'habdc);
		rdx(16'hc010, 32'h0000_0000);
		wr(OFF_SPEED, 32'h0000_fff0);
		rdx(OFF_SPEED, 32'h0000_0000);
		for (p = 0; p < 16; p++) begin
			wr(OFF_SPEED, p);
			cy(2);
			k = 0;
			repeat (4 * (p + 1)) begin
				@(posedge i_mclk);
				if (clk_en === 1'b1)
					k++;
			end
			chk(k, 4);
		end
		wr(OFF_POWER, 32'h0000_ffbc);
		rdx(OFF_POWER, 32'h0000_fb90);
		boost <= 1;
		cy(6);
		rdx(OFF_POWER, 32'h0000_fb94);
		boost <= 0;
		// Pin wake only: a port change must not wake, clocks stay stopped
		wr(OFF_POWER, 32'h0000_0012);
		cy(2);
		chk(slp, 1);
		usb[0] <= ~usb[0];
		k = 0;
		repeat (30) begin
			@(posedge i_mclk);
			if (clk_en === 1'b1)
				k++;
		end
		chk(k, 0);
		chk(slp, 1);
		poke(9);
		wake_wait();
		for (p = 0; p < 11; p++) begin
			wr(OFF_POWER, {16'h0000, en_tab[p] | 16'h0002});
			cy(2);
			chk(slp, 1);
			poke(p);
			wake_wait();
			ssn <= 1'b1;
			rdx(OFF_POWER, {16'h0000, en_tab[p]});
		end
		wr(OFF_POWER, 32'h0000_0001);
		cy(2);
		chk(hlt, 1);
		irq <= 1;
		k = 0;
		while (hlt !== 1'b0 && k < 50) begin
			@(posedge i_mclk);
			k++;
		end
		chk(hlt, 0);
		irq <= 0;
		results();
	end
endmodule
